// *** core/wwd_pkg.sv ***
// Constants shared by the window watchdog design and its bench.
package wwd_pkg;

    // Register indices on the 4-bit register port.
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_CONFIG = 4'h1;
    localparam logic [3:0] ADDR_EWCTRL = 4'h2;
    localparam logic [3:0] ADDR_INTENCLR = 4'h4;
    localparam logic [3:0] ADDR_INTENSET = 4'h5;
    localparam logic [3:0] ADDR_INT_FLAG = 4'h6;
    localparam logic [3:0] ADDR_STATUS = 4'h7;
    localparam logic [3:0] ADDR_CLEAR = 4'h8;

    // Field positions.
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_WINDOW_BIT = 2;
    localparam int CTRL_LOCK_BIT = 7;
    localparam int CFG_PERIOD_LSB = 0;
    localparam int CFG_WIN_LSB = 4;
    localparam int WARN_ENABLE_BIT = 0;

    // Values after reset.
    localparam logic RST_ENABLE = 1'b0;
    localparam logic RST_WINDOW = 1'b0;
    localparam logic RST_LOCK = 1'b0;
    localparam logic [3:0] RST_PERIOD = 4'h0;
    localparam logic [3:0] RST_WIN = 4'h0;
    localparam logic [3:0] RST_LEAD = 4'h0;

    // Clear key and period encoding.
    localparam logic [7:0] CLEAR_KEY = 8'ha5;
    localparam logic [15:0] MIN_PERIOD = 16'h0008;
    localparam logic [3:0] MAX_SELECT = 4'hb;

    // Phase of the counting sequence.
    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_CLOSED = 2'b01,
        PH_OPEN = 2'b10
    } wwd_phase_t;

endpackage

// *** core/wwd_core.sv ***
// Window watchdog core: register port, count-clock sampling and counter.
`timescale 1ns/100ps
// What this block does
// - Count while enabled; reset the system when a period ends uncleared.
// - Offer an optional early-warning interrupt before the time-out.
// - Window mode: clear before window opens resets; late clear also resets.
// - Normal-mode period selectable from 8 to 16,384 count-clock cycles.
// - Window-mode total period selectable from 16 to 32,768 cycles.
// - Counter keeps running in active and all sleep modes.
// - Apart from the bad-key reset, reset and warning timing derive only from the count clock.
// - Interrupt line can serve as a wake-up source from sleep.
// - Register interface is live right after reset.
// - Accesses crossing into the count domain pass a synchroniser.
// - Debug halt freezes counting and suppresses time-out reset and warning.
// - Write protection blocks all writes except the interrupt flag.
// - Clear key 0xA5 restarts the period; other values reset at once while enabled or running.
// - Window mode with warning: interrupt when the open window starts.
// - Window, lock, configuration and lead writes ignored while enabled.
// - Disable takes effect only while the persist lock is zero.

module wwd_core (
    // Clock and reset.
    input wire logic clk,
    input wire logic resetn,
    // Register port.
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdata,
    // Count clock, debug halt and write protection.
    input wire logic watchdogCountClock,
    input wire logic debugHalt,
    input wire logic writeProtect,
    // Outputs to reset and interrupt logic.
    output logic systemReset,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////

    // Cycles for a 4-bit period select; codes above the top one saturate.
    function automatic logic [15:0] periodCycles(input logic [3:0] sel);
        logic [3:0] s;
        s = (sel > wwd_pkg::MAX_SELECT) ? wwd_pkg::MAX_SELECT : sel;
        periodCycles = wwd_pkg::MIN_PERIOD << s;
    endfunction

    logic enable;
    logic windowMode;
    logic persistLock;
    logic [3:0] periodSel;
    logic [3:0] windowSel;
    logic [3:0] leadSel;
    logic warnEnable;
    logic warnFlag;
    logic clearPending;
    logic running;
    logic [15:0] count;
    wwd_pkg::wwd_phase_t phase;
    logic cntSync1;
    logic cntSync2;
    logic cntSync3;

    ////////////////////////////////////////////////////////////////////////

    // Register port decode. The port is usable from the first edge after
    // reset release; nothing waits on the count clock to accept an access.
    wire writeOk = regWrite
        & (~writeProtect | regAddr == wwd_pkg::ADDR_INT_FLAG);
    wire wrCtrl = writeOk & (regAddr == wwd_pkg::ADDR_CTRL);
    wire wrConfig = writeOk & (regAddr == wwd_pkg::ADDR_CONFIG);
    wire wrEwctrl = writeOk & (regAddr == wwd_pkg::ADDR_EWCTRL);
    wire wrIntClr = writeOk & (regAddr == wwd_pkg::ADDR_INTENCLR);
    wire wrIntSet = writeOk & (regAddr == wwd_pkg::ADDR_INTENSET);
    wire wrFlag = writeOk & (regAddr == wwd_pkg::ADDR_INT_FLAG);
    wire wrClear = writeOk & (regAddr == wwd_pkg::ADDR_CLEAR);
    wire active = enable | running;
    wire keyGood = wrClear & (regWdata == wwd_pkg::CLEAR_KEY);
    wire keyBad = wrClear & (regWdata != wwd_pkg::CLEAR_KEY) & active;

    // Configuration is frozen whenever enable is set, which covers both
    // the enabled and the still-enabling states.
    wire cfgOpen = ~enable;
    wire next_enable = wrCtrl ? (regWdata[wwd_pkg::CTRL_ENABLE_BIT]
                                 | (enable & persistLock)) : enable;
    wire next_windowMode = (wrCtrl & cfgOpen)
                           ? regWdata[wwd_pkg::CTRL_WINDOW_BIT] : windowMode;
    wire next_persistLock = (wrCtrl & cfgOpen)
                            ? regWdata[wwd_pkg::CTRL_LOCK_BIT] : persistLock;
    wire next_warnEnable = wrIntSet & regWdata[wwd_pkg::WARN_ENABLE_BIT] ? 1'b1
                         : wrIntClr & regWdata[wwd_pkg::WARN_ENABLE_BIT] ? 1'b0
                         : warnEnable;

    ////////////////////////////////////////////////////////////////////////

    // Count-clock sampling. The count clock is much slower than clk, so a
    // rising edge seen after two flops gives one tick per count cycle.
    wire tick = cntSync2 & ~cntSync3;
    // A halted CPU stops the count; timing events cannot fire meanwhile.
    wire step = tick & ~debugHalt;

    wire [15:0] closedCycles = periodCycles(windowSel);
    wire [15:0] openCycles = periodCycles(periodSel);
    wire [15:0] leadCycles = periodCycles(leadSel);
    wire [15:0] countInc = 16'(count + 16'h0001);

    logic next_running;
    logic [15:0] next_count;
    wwd_pkg::wwd_phase_t next_phase;
    logic timeoutHit;
    logic warnHit;
    logic consume;

    // Counting sequence. No sleep input exists: once running, only the
    // count clock and debug halt decide progress.
    always_comb begin
        next_running = running;
        next_count = count;
        next_phase = phase;
        timeoutHit = 1'b0;
        warnHit = 1'b0;
        consume = 1'b0;
        if (step) begin
            consume = 1'b1;
            if (!running) begin
                if (enable) begin
                    next_running = 1'b1;
                    next_count = 16'h0000;
                    next_phase = windowMode ? wwd_pkg::PH_CLOSED
                                            : wwd_pkg::PH_OPEN;
                end
            end else if (!enable) begin
                next_running = 1'b0;
                next_count = 16'h0000;
                next_phase = wwd_pkg::PH_IDLE;
            end else if (clearPending) begin
                if (phase == wwd_pkg::PH_CLOSED) begin
                    timeoutHit = 1'b1;
                end else begin
                    next_count = 16'h0000;
                    next_phase = windowMode ? wwd_pkg::PH_CLOSED
                                            : wwd_pkg::PH_OPEN;
                end
            end else begin
                next_count = countInc;
                case (phase)
                    wwd_pkg::PH_CLOSED: begin
                        if (countInc == closedCycles) begin
                            next_count = 16'h0000;
                            next_phase = wwd_pkg::PH_OPEN;
                            warnHit = 1'b1;
                        end
                    end
                    wwd_pkg::PH_OPEN: begin
                        if (countInc == openCycles) begin
                            timeoutHit = 1'b1;
                        end
                        if (!windowMode && countInc == leadCycles) begin
                            warnHit = 1'b1;
                        end
                    end
                    default: begin
                        next_phase = wwd_pkg::PH_IDLE;
                    end
                endcase
            end
        end
    end

    // A warning arriving with a write-one clear still sets the flag.
    wire next_warnFlag = (warnFlag
                         & ~(wrFlag & regWdata[wwd_pkg::WARN_ENABLE_BIT]))
                         | warnHit;
    wire next_clearPending = (clearPending & ~consume) | keyGood;
    wire syncBusy = clearPending | (enable != running);

    ////////////////////////////////////////////////////////////////////////

    // Read mux; unmapped and reserved bits read zero.
    logic [7:0] readValue;
    always_comb begin
        case (regAddr)
            wwd_pkg::ADDR_CTRL:
                readValue = {persistLock, 4'h0, windowMode, 1'b0, enable};
            wwd_pkg::ADDR_CONFIG:
                readValue = {windowSel, periodSel};
            wwd_pkg::ADDR_EWCTRL:
                readValue = {4'h0, leadSel};
            wwd_pkg::ADDR_INTENCLR,
            wwd_pkg::ADDR_INTENSET:
                readValue = {7'h00, warnEnable};
            wwd_pkg::ADDR_INT_FLAG:
                readValue = {7'h00, warnFlag};
            wwd_pkg::ADDR_STATUS:
                readValue = {4'h0, phase, syncBusy, running};
            default:
                readValue = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cntSync1 <= 1'b0;
            cntSync2 <= 1'b0;
            cntSync3 <= 1'b0;
        end else begin
            cntSync1 <= watchdogCountClock;
            cntSync2 <= cntSync1;
            cntSync3 <= cntSync2;
        end
    end

    // One register to a process keeps each reset value beside its load.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            enable <= wwd_pkg::RST_ENABLE;
        end else begin
            enable <= next_enable;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            windowMode <= wwd_pkg::RST_WINDOW;
        end else begin
            windowMode <= next_windowMode;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            persistLock <= wwd_pkg::RST_LOCK;
        end else begin
            persistLock <= next_persistLock;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            warnEnable <= 1'b0;
        end else begin
            warnEnable <= next_warnEnable;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            periodSel <= wwd_pkg::RST_PERIOD;
        end else begin
            if (wrConfig && cfgOpen) begin
                periodSel <= regWdata[wwd_pkg::CFG_PERIOD_LSB +: 4];
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            windowSel <= wwd_pkg::RST_WIN;
        end else begin
            if (wrConfig && cfgOpen) begin
                windowSel <= regWdata[wwd_pkg::CFG_WIN_LSB +: 4];
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            leadSel <= wwd_pkg::RST_LEAD;
        end else begin
            if (wrEwctrl && cfgOpen) begin
                leadSel <= regWdata[3:0];
            end
        end
    end

    // Counter state moves only on count ticks; clk alone never advances
    // it, so a clear left pending through a halt lands at the next tick.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            running <= 1'b0;
        end else begin
            running <= next_running;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            count <= 16'h0000;
        end else begin
            count <= next_count;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            phase <= wwd_pkg::PH_IDLE;
        end else begin
            phase <= next_phase;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            clearPending <= 1'b0;
        end else begin
            clearPending <= next_clearPending;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            warnFlag <= 1'b0;
        end else begin
            warnFlag <= next_warnFlag;
        end
    end

    // The reset request holds until the system reset comes back through
    // resetn, so a short-lived request cannot be missed downstream.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            systemReset <= 1'b0;
        end else begin
            systemReset <= systemReset | timeoutHit | keyBad;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            regRdata <= 8'h00;
        end else begin
            regRdata <= regRead ? readValue : 8'h00;
        end
    end

    // Combinational from flag and enable so it also works as a wake-up
    // request with clk stopped upstream.
    assign irq = warnFlag & warnEnable;

endmodule // wwd_core

// *** tb/wwd_count_src.sv ***
// Behavioural count clock source standing in front of the watchdog core.
`timescale 1ns/100ps
module wwd_count_src #(
    parameter int HALF = 170
) (
    // Control.
    input wire logic run,
    // Count clock.
    output logic countClock
);
    // The clock stays low until the system switches it on.
    // HALF is not a multiple of the bus period, yet a full period is 17 bus periods, so edges keep a fixed phase.
    initial begin
        countClock = 1'b0;
        forever begin
            #(HALF);
            countClock = run ? ~countClock : 1'b0;
        end
    end
endmodule // wwd_count_src

// *** tb/wwd_core_assertions.sv ***
// Port checker for the window watchdog core.
`timescale 1ns/100ps
module wwd_core_checker (
    // Clock and reset.
    input wire logic clk,
    input wire logic resetn,
    // Register port.
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regRdata,
    // Side signals.
    input wire logic watchdogCountClock,
    input wire logic debugHalt,
    input wire logic writeProtect,
    input wire logic systemReset,
    input wire logic irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    logic enSeen;
    wire wrOk = regWrite && !writeProtect;
    wire badKey = enSeen && wrOk && regAddr == wwd_pkg::ADDR_CLEAR
        && regWdata != wwd_pkg::CLEAR_KEY;
    wire flagWr = regWrite && regAddr == wwd_pkg::ADDR_INT_FLAG && regWdata[0];
    wire enClr = wrOk && regAddr == wwd_pkg::ADDR_INTENCLR && regWdata[0];
    // A loose copy of enable: it may miss cases but never misfires.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            enSeen <= 1'b0;
        end else if (wrOk && regAddr == wwd_pkg::ADDR_CTRL) begin
            enSeen <= regWdata[0];
        end
    end
    ////////////////////////////////////////////////////////////////////////
    property p_sticky; systemReset |=> systemReset; endproperty
    a_sticky: assert property (p_sticky) else $error("reset dropped");
    property p_badKey; badKey |-> ##[1:2] systemReset; endproperty
    a_badKey: assert property (p_badKey) else $error("bad key kept");
    property p_haltRst;
        (debugHalt && !regWrite) [*4] |=> !$rose(systemReset);
    endproperty
    a_haltRst: assert property (p_haltRst) else $error("halt reset");
    property p_haltIrq; (debugHalt && !regWrite) [*4] |=> !$rose(irq); endproperty
    a_haltIrq: assert property (p_haltIrq) else $error("halt irq");
    property p_flagClr; debugHalt [*4] ##0 flagWr |=> !irq; endproperty
    a_flagClr: assert property (p_flagClr) else $error("flag kept");
    property p_enClr; enClr |=> !irq; endproperty
    a_enClr: assert property (p_enClr) else $error("irq kept");
    property p_rdIdle; !$past(regRead) |-> regRdata == 8'h00; endproperty
    a_rdIdle: assert property (p_rdIdle) else $error("idle data");
    property p_unmap;
        regRead && regAddr > wwd_pkg::ADDR_CLEAR |=> regRdata == 8'h00;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped data");
    c_rst: cover property ($rose(systemReset));
    c_irq: cover property ($rose(irq));
    c_bad: cover property (badKey);
endmodule // wwd_core_checker
bind wwd_core wwd_core_checker wwd_core_checker_i (.clk(clk),
    .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .watchdogCountClock(watchdogCountClock), .debugHalt(debugHalt),
    .writeProtect(writeProtect), .systemReset(systemReset), .irq(irq));

// *** tb/tb_top.sv ***
// Self-checking bench for the window watchdog core.
`timescale 1ns/100ps
module tb_top;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [3:0] regAddr = 4'h0;
    logic [7:0] regWdata = 8'h00;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [7:0] regRdata;
    logic countClock;
    logic debugHalt = 1'b0;
    logic writeProtect = 1'b0;
    logic run = 1'b0;
    logic systemReset;
    logic irq;
    logic rdPend = 1'b0;
    logic [7:0] expQ[$];
    int n_mismatch = 0;
    int checks_done = 0;
    always #10 clk = ~clk;
    wwd_count_src wwd_count_src_i (.run(run), .countClock(countClock));
    wwd_core wwd_core_i (.clk(clk), .resetn(resetn), .regAddr(regAddr),
        .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
        .regRdata(regRdata), .watchdogCountClock(countClock),
        .debugHalt(debugHalt), .writeProtect(writeProtect),
        .systemReset(systemReset), .irq(irq));
    ////////////////////////////////////////////////////////////////////////
    task chk(input string name, input logic [7:0] seen, input logic [7:0] e);
        checks_done++;
        if (seen !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", name, e, seen);
        end
    endtask
    task complete_run();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask
    task rd(input logic [3:0] a, input logic [7:0] e);
        expQ.push_back(e);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
    endtask
    // Bounded wait for irq or for the reset output.
    task await(input logic wantIrq, input int n);
        while (n > 0 && (wantIrq ? irq : systemReset) !== 1'b1) begin
            @(posedge clk);
            n--;
        end
        chk("wait", {7'h00, wantIrq ? irq : systemReset}, 8'h01);
        if (n_mismatch > 0) begin
            complete_run();
        end
    endtask
    task restart();
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
    endtask
    // Read data stand one cycle after the strobe, so the strobe is noted first.
    always @(posedge clk) begin
        if (rdPend) begin
            chk("read data", regRdata, expQ.pop_front());
        end
        rdPend = regRead;
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(61433));
        restart();
        run <= 1'b1;
        rd(wwd_pkg::ADDR_CTRL, 8'h00);
        rd(wwd_pkg::ADDR_STATUS, 8'h00);
        rd(4'hf, 8'h00);
        writeProtect <= 1'b1;
        wr(wwd_pkg::ADDR_CTRL, 8'h01);
        rd(wwd_pkg::ADDR_CTRL, 8'h00);
        writeProtect <= 1'b0;
        wr(wwd_pkg::ADDR_CONFIG, 8'h01);
        wr(wwd_pkg::ADDR_INTENSET, 8'h01);
        wr(wwd_pkg::ADDR_CTRL, 8'h01);
        await(1'b1, 17 * 14);
        chk("early reset", {7'h00, systemReset}, 8'h00);
        rd(wwd_pkg::ADDR_STATUS, 8'h09);
        debugHalt <= 1'b1;
        repeat (4) @(posedge clk);
        writeProtect <= 1'b1;
        wr(wwd_pkg::ADDR_INT_FLAG, 8'h01);
        @(posedge clk);
        chk("flag clear", {7'h00, irq}, 8'h00);
        writeProtect <= 1'b0;
        repeat (17 * 20) @(posedge clk);
        chk("halted", {6'h00, irq, systemReset}, 8'h00);
        wr(wwd_pkg::ADDR_CONFIG, 8'($urandom()));
        rd(wwd_pkg::ADDR_CONFIG, 8'h01);
        debugHalt <= 1'b0;
        wr(wwd_pkg::ADDR_CLEAR, wwd_pkg::CLEAR_KEY);
        repeat (17 * 12) @(posedge clk);
        chk("period", {7'h00, systemReset}, 8'h00);
        await(1'b0, 17 * 8);
        restart();
        wr(wwd_pkg::ADDR_CTRL, 8'h01);
        wr(wwd_pkg::ADDR_CLEAR, wwd_pkg::CLEAR_KEY ^ (8'($urandom()) | 8'h01));
        repeat (2) @(posedge clk);
        chk("bad key", {7'h00, systemReset}, 8'h01);
        restart();
        wr(wwd_pkg::ADDR_INTENSET, 8'h01);
        wr(wwd_pkg::ADDR_CTRL, 8'h85);
        wr(wwd_pkg::ADDR_CTRL, 8'h00);
        rd(wwd_pkg::ADDR_CTRL, 8'h85);
        repeat (17 * 5) @(posedge clk);
        chk("closed", {7'h00, irq}, 8'h00);
        await(1'b1, 17 * 6);
        wr(wwd_pkg::ADDR_INTENCLR, 8'h01);
        @(posedge clk);
        chk("irq off", {7'h00, irq}, 8'h00);
        wr(wwd_pkg::ADDR_CLEAR, wwd_pkg::CLEAR_KEY);
        repeat (17 * 2) @(posedge clk);
        chk("open clear", {7'h00, systemReset}, 8'h00);
        wr(wwd_pkg::ADDR_CLEAR, wwd_pkg::CLEAR_KEY);
        await(1'b0, 17 * 3);
        repeat (2) @(posedge clk);
        complete_run();
    end
endmodule // tb_top
